/* File: src/tmr_consts.svh */
// constants of the general 16-bit timer: register addresses, reset values, prescaler counts
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ************************************************************
// register addresses on the special-function register port
// ************************************************************
`define TMR_ADDR_CONTROL   8'hc8
`define TMR_ADDR_MODE      8'hc9
`define TMR_ADDR_CAP_LOW   8'hca
`define TMR_ADDR_CAP_HIGH  8'hcb
`define TMR_ADDR_CNT_LOW   8'hcc
`define TMR_ADDR_CNT_HIGH  8'hcd

// ************************************************************
// reset values
// ************************************************************
`define TMR_RST_CONTROL    8'h00
`define TMR_RST_MODE       8'h00
`define TMR_RST_WORD       16'h0000
`define TMR_RD_UNMAPPED    8'h00

// ************************************************************
// field positions and counts
// ************************************************************
`define TMR_MODE_BITS      2
`define TMR_CNT_MAX        16'hffff
`define TMR_DIV_SLOW       12
`define TMR_DIV_FAST       4
`define TMR_DIV_BAUD       2
`define TMR_PRESC_W        4

`endif

/* File: src/tmr_pkg.sv */
// types of the general 16-bit timer
`default_nettype none

package tmr_pkg;

  // control register, msb first
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_baud_select;
    logic transmit_baud_select;
    logic external_enable;
    logic run_bit;
    logic counter_select;
    logic capture_reload_select;
  } ctrl_t;

  // mode register, reserved bits read zero
  typedef struct packed {
    logic [5:0] reserved;
    logic       clock_output_enable;
    logic       down_count_enable;
  } mode_t;

endpackage : tmr_pkg

`default_nettype wire

/* File: src/edge_sync.sv */
// two-flop synchroniser with falling-edge detect for one pin
`default_nettype none

module edge_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin_i,
  output var  logic level,
  output var  logic fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;
  logic meta_nxt;
  logic sync_nxt;
  logic last_nxt;

  // shift chain; only sync_r reads meta_r
  always_comb begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  // idle level is high, so no false edge at release
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  assign level = sync_r;
  assign fall  = last_r & ~sync_r;

endmodule : edge_sync

`default_nettype wire

/* File: src/timer2_capture_reload_baud.sv */
// 16-bit general timer/counter with capture, auto-reload, baud generation and clock output
`include "tmr_consts.svh"
`default_nettype none

module timer2_capture_reload_baud #(
  parameter int DIV_SLOW = `TMR_DIV_SLOW,
  parameter int DIV_FAST = `TMR_DIV_FAST,
  parameter int DIV_BAUD = `TMR_DIV_BAUD
) (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output var  logic [7:0] SFR_RDATA,
  input  wire logic       TIMER_SPEED_BIT,
  input  wire logic       COUNT_INPUT_PIN_I,
  output var  logic       COUNT_INPUT_PIN_O,
  output var  logic       COUNT_INPUT_PIN_OE_N,
  input  wire logic       TRIGGER_PIN,
  input  wire logic       TIMER1_OVF,
  input  wire logic       IRQ_ENABLE,
  output var  logic       TIMER_IRQ,
  output var  logic       RX_BAUD_TICK,
  output var  logic       TX_BAUD_TICK
);

  import tmr_pkg::*;

  localparam logic [`TMR_PRESC_W-1:0] DIV_SLOW_M1 = `TMR_PRESC_W'(DIV_SLOW - 1);
  localparam logic [`TMR_PRESC_W-1:0] DIV_FAST_M1 = `TMR_PRESC_W'(DIV_FAST - 1);
  localparam logic [`TMR_PRESC_W-1:0] DIV_BAUD_M1 = `TMR_PRESC_W'(DIV_BAUD - 1);

  // ************************************************************
  // state
  // ************************************************************
  ctrl_t                   ctrl_r;
  ctrl_t                   ctrl_nxt;
  mode_t                   mode_r;
  mode_t                   mode_nxt;
  logic [15:0]             cnt_r;
  logic [15:0]             cnt_nxt;
  logic [15:0]             cap_r;
  logic [15:0]             cap_nxt;
  logic [`TMR_PRESC_W-1:0] presc_r;
  logic [`TMR_PRESC_W-1:0] presc_nxt;
  logic                    clk_out_r;
  logic                    clk_out_nxt;
  logic                    rx_tick_r;
  logic                    rx_tick_nxt;
  logic                    tx_tick_r;
  logic                    tx_tick_nxt;
  logic [7:0]              rdata_r;
  logic [7:0]              rdata_nxt;

  // ************************************************************
  // decoded modes and events
  // ************************************************************
  logic                    cnt_fall;
  logic                    trig_level;
  logic                    trig_fall;
  logic                    baud;
  logic                    clkout_mode;
  logic                    fast;
  logic                    reload_mode;
  logic                    toggle_mode;
  logic                    count_down;
  logic [`TMR_PRESC_W-1:0] div_m1;
  logic                    presc_hit;
  logic                    tick;
  logic                    wrap_up;
  logic                    wrap_dn;
  logic                    roll;
  logic                    trig_evt;
  logic                    ext_act;
  logic                    edge_set;
  logic                    wr_ctrl;

  // pin synchronisers
  edge_sync u_count_sync (
    .clk   (CLK),
    .srst  (SRST),
    .pin_i (COUNT_INPUT_PIN_I),
    .level (),
    .fall  (cnt_fall)
  );

  edge_sync u_trig_sync (
    .clk   (CLK),
    .srst  (SRST),
    .pin_i (TRIGGER_PIN),
    .level (trig_level),
    .fall  (trig_fall)
  );

  // mode decode
  assign baud        = ctrl_r.receive_baud_select | ctrl_r.transmit_baud_select;
  assign clkout_mode = mode_r.clock_output_enable & ~ctrl_r.counter_select;
  assign fast        = baud | clkout_mode;
  assign reload_mode = baud | ~ctrl_r.capture_reload_select;
  assign toggle_mode = reload_mode & ~baud & mode_r.down_count_enable;
  assign count_down  = toggle_mode & ~trig_level;

  // prescaler compare; >= keeps a divider change from stranding the count
  always_comb begin
    if (fast) begin
      div_m1 = DIV_BAUD_M1;
    end else if (TIMER_SPEED_BIT) begin
      div_m1 = DIV_FAST_M1;
    end else begin
      div_m1 = DIV_SLOW_M1;
    end
  end
  assign presc_hit = presc_r >= div_m1;

  // count tick, rollover and trigger events
  assign tick      = ctrl_r.run_bit &
                     ((ctrl_r.counter_select & ~fast) ? cnt_fall : presc_hit);
  assign wrap_up   = tick & ~count_down & (cnt_r == `TMR_CNT_MAX);
  assign wrap_dn   = tick & count_down & (cnt_r == cap_r);
  assign roll      = wrap_up | wrap_dn;
  assign trig_evt  = ctrl_r.external_enable & trig_fall;
  assign ext_act   = trig_evt & ~baud;
  assign edge_set  = trig_evt &
                     (ctrl_r.capture_reload_select | ~mode_r.down_count_enable);
  assign wr_ctrl   = SFR_WR & (SFR_ADDR == `TMR_ADDR_CONTROL);

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    // control: software write first, hardware sets win over the clear
    ctrl_nxt = wr_ctrl ? ctrl_t'(SFR_WDATA) : ctrl_r;
    if (roll & ~baud) begin
      ctrl_nxt.overflow_flag = 1'b1;
    end
    if (edge_set) begin
      ctrl_nxt.external_flag = 1'b1;
    end
    if (toggle_mode & roll) begin
      ctrl_nxt.external_flag = ~ctrl_nxt.external_flag;
    end

    mode_nxt = mode_r;
    if (SFR_WR & (SFR_ADDR == `TMR_ADDR_MODE)) begin
      mode_nxt = '{reserved: 6'h00, clock_output_enable: SFR_WDATA[1],
                   down_count_enable: SFR_WDATA[0]};
    end

    // prescaler runs only while the timer runs
    presc_nxt = presc_r;
    if (ctrl_r.run_bit) begin
      presc_nxt = presc_hit ? '0 : presc_r + `TMR_PRESC_W'(1);
    end

    // counter; ticks only while running, trigger reload and writes still apply when halted
    cnt_nxt = cnt_r;
    if (tick) begin
      cnt_nxt = count_down ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
    end
    if (wrap_up & reload_mode) begin
      cnt_nxt = cap_r;
    end
    if (wrap_dn) begin
      cnt_nxt = `TMR_CNT_MAX;
    end
    if (ext_act & ~ctrl_r.capture_reload_select & ~mode_r.down_count_enable) begin
      cnt_nxt = cap_r;
    end
    if (SFR_WR & (SFR_ADDR == `TMR_ADDR_CNT_LOW)) begin
      cnt_nxt[7:0] = SFR_WDATA;
    end
    if (SFR_WR & (SFR_ADDR == `TMR_ADDR_CNT_HIGH)) begin
      cnt_nxt[15:8] = SFR_WDATA;
    end

    // capture pair: capture on trigger, also the reload word
    cap_nxt = cap_r;
    if (ext_act & ctrl_r.capture_reload_select & ~baud) begin
      cap_nxt = cnt_r;
    end
    if (SFR_WR & (SFR_ADDR == `TMR_ADDR_CAP_LOW)) begin
      cap_nxt[7:0] = SFR_WDATA;
    end
    if (SFR_WR & (SFR_ADDR == `TMR_ADDR_CAP_HIGH)) begin
      cap_nxt[15:8] = SFR_WDATA;
    end

    // clock output toggles on each rollover
    clk_out_nxt = (clkout_mode & roll) ? ~clk_out_r : clk_out_r;

    // baud tick sources for the serial port
    rx_tick_nxt = ctrl_r.receive_baud_select ? roll : TIMER1_OVF;
    tx_tick_nxt = ctrl_r.transmit_baud_select ? roll : TIMER1_OVF;

    // read mux, unmapped reads zero
    rdata_nxt = rdata_r;
    if (SFR_RD) begin
      unique case (SFR_ADDR)
        `TMR_ADDR_CONTROL:  rdata_nxt = ctrl_r;
        `TMR_ADDR_MODE:     rdata_nxt = mode_r;
        `TMR_ADDR_CAP_LOW:  rdata_nxt = cap_r[7:0];
        `TMR_ADDR_CAP_HIGH: rdata_nxt = cap_r[15:8];
        `TMR_ADDR_CNT_LOW:  rdata_nxt = cnt_r[7:0];
        `TMR_ADDR_CNT_HIGH: rdata_nxt = cnt_r[15:8];
        default:            rdata_nxt = `TMR_RD_UNMAPPED;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_r    <= ctrl_t'(`TMR_RST_CONTROL);
      mode_r    <= mode_t'(`TMR_RST_MODE);
      cnt_r     <= `TMR_RST_WORD;
      cap_r     <= `TMR_RST_WORD;
      presc_r   <= '0;
      clk_out_r <= 1'b0;
      rx_tick_r <= 1'b0;
      tx_tick_r <= 1'b0;
      rdata_r   <= `TMR_RD_UNMAPPED;
    end else begin
      ctrl_r    <= ctrl_nxt;
      mode_r    <= mode_nxt;
      cnt_r     <= cnt_nxt;
      cap_r     <= cap_nxt;
      presc_r   <= presc_nxt;
      clk_out_r <= clk_out_nxt;
      rx_tick_r <= rx_tick_nxt;
      tx_tick_r <= tx_tick_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign SFR_RDATA            = rdata_r;
  assign COUNT_INPUT_PIN_O    = clk_out_r;
  assign COUNT_INPUT_PIN_OE_N = ~clkout_mode;
  assign RX_BAUD_TICK         = rx_tick_r;
  assign TX_BAUD_TICK         = tx_tick_r;
  // merged request; toggle-mode flag and clock-out rollovers do not interrupt
  assign TIMER_IRQ = IRQ_ENABLE &
                     ((ctrl_r.overflow_flag & ~clkout_mode) |
                      (ctrl_r.external_flag & ~toggle_mode));

endmodule : timer2_capture_reload_baud

`default_nettype wire

/* File: verif/tmr_chk.sv */
// port assertions for the 16-bit timer
`default_nettype none
// ********
// checker
// ********
module tmr_chk (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       COUNT_INPUT_PIN_O,
  input wire logic       COUNT_INPUT_PIN_OE_N,
  input wire logic       TIMER1_OVF,
  input wire logic       IRQ_ENABLE,
  input wire logic       TIMER_IRQ,
  input wire logic       RX_BAUD_TICK,
  input wire logic       TX_BAUD_TICK
);
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [1:0] md_r;
  logic [1:0] md_nxt;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // shadow of the control bits that only software changes
  always_comb begin
    ctl_nxt = ctl_r;
    md_nxt  = md_r;
    if (SFR_WR && SFR_ADDR == 8'hc8)
      ctl_nxt = SFR_WDATA;
    if (SFR_WR && SFR_ADDR == 8'hc9)
      md_nxt = SFR_WDATA[1:0];
    if (SRST) begin
      ctl_nxt = 8'h00;
      md_nxt  = 2'h0;
    end
  end
  always_ff @(posedge CLK) begin
    ctl_r <= ctl_nxt;
    md_r  <= md_nxt;
  end
  sequence s_ext_set;
    SFR_WR && SFR_ADDR == 8'hc8 && SFR_WDATA[6] && IRQ_ENABLE;
  endsequence
  property p_rst;
    disable iff (1'b0) $fell(SRST) |-> SFR_RDATA == 8'h00 && COUNT_INPUT_PIN_OE_N && !TIMER_IRQ;
  endproperty
  property p_irq;
    !IRQ_ENABLE |-> !TIMER_IRQ;
  endproperty
  property p_rx;
    !ctl_r[5] |=> RX_BAUD_TICK == $past(TIMER1_OVF);
  endproperty
  property p_tx;
    !ctl_r[4] |=> TX_BAUD_TICK == $past(TIMER1_OVF);
  endproperty
  property p_oe;
    COUNT_INPUT_PIN_OE_N == !(md_r[1] && !ctl_r[1]);
  endproperty
  property p_pin;
    $changed(COUNT_INPUT_PIN_O) |=> $stable(COUNT_INPUT_PIN_O);
  endproperty
  property p_gap;
    ctl_r[5] && $past(ctl_r[5]) && RX_BAUD_TICK |=> !RX_BAUD_TICK;
  endproperty
  property p_sw;
    s_ext_set ##0 !(md_r[0] && !SFR_WDATA[0]) |=> TIMER_IRQ || !IRQ_ENABLE;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  a_irq: assert property (p_irq) else $error("request while disabled");
  a_rx: assert property (p_rx) else $error("rx tick not from other timer");
  a_tx: assert property (p_tx) else $error("tx tick not from other timer");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_pin: assert property (p_pin) else $error("clock out faster than two clocks");
  a_gap: assert property (p_gap) else $error("baud ticks too close");
  a_sw: assert property (p_sw) else $error("software flag set gave no request");
endmodule : tmr_chk

bind timer2_capture_reload_baud tmr_chk u_chk (
  .CLK(CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
  .SFR_RDATA(SFR_RDATA), .COUNT_INPUT_PIN_O(COUNT_INPUT_PIN_O), .COUNT_INPUT_PIN_OE_N(COUNT_INPUT_PIN_OE_N),
  .TIMER1_OVF(TIMER1_OVF), .IRQ_ENABLE(IRQ_ENABLE), .TIMER_IRQ(TIMER_IRQ),
  .RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK));
`default_nettype wire

/* File: verif/pin_model.sv */
// far side: trigger and count pins, serial port tick counters
`default_nettype none
module pin_model (
  input  wire logic clk,
  input  wire logic trig_go,
  input  wire logic dir_lo,
  input  wire logic cnt_go,
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  input  wire logic rx_tick,
  input  wire logic tx_tick,
  output var  logic trig,
  output var  logic cnt_pin,
  output var  int   rx_n,
  output var  int   tx_n
);
  logic [2:0] tq = 3'h0;
  logic [2:0] cq = 3'h0;
  // five-cycle low pulses on command, ticks counted as the port would
  always_ff @(posedge clk) begin
    tq   <= trig_go ? 3'h5 : tq - 3'(tq != 3'h0);
    cq   <= cnt_go ? 3'h5 : cq - 3'(cq != 3'h0);
    rx_n <= rx_n + int'(rx_tick);
    tx_n <= tx_n + int'(tx_tick);
  end
  // low trigger level asks for down count
  assign trig    = !dir_lo && tq == 3'h0;
  // pull-up when the device does not drive the pin
  assign cnt_pin = !pin_oe_n ? pin_o : cq == 3'h0;
endmodule : pin_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench of the 16-bit timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, ovf1 = 1'b0, irq_en = 1'b1;
  logic       tg = 1'b0, dlo = 1'b0, cg = 1'b0, spd = 1'b1, pin_o, oe_n, trig, cpin, irq, rxt, txt;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, rv, d;
  int         rx_n, tx_n, error_cnt = 0, compares = 0, seed = 60, n1 = 0, r0, t0, m0;
  timer2_capture_reload_baud u_timer2_capture_reload_baud (.CLK(clk), .SRST(srst), .SFR_ADDR(addr),
    .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_WDATA(wdat), .SFR_RDATA(rdat), .TIMER_SPEED_BIT(spd),
    .COUNT_INPUT_PIN_I(cpin), .COUNT_INPUT_PIN_O(pin_o), .COUNT_INPUT_PIN_OE_N(oe_n), .TRIGGER_PIN(trig),
    .TIMER1_OVF(ovf1), .IRQ_ENABLE(irq_en), .TIMER_IRQ(irq), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt));
  pin_model u_pin_model (.clk(clk), .trig_go(tg), .dir_lo(dlo), .cnt_go(cg), .pin_o(pin_o), .pin_oe_n(oe_n),
    .rx_tick(rxt), .tx_tick(txt), .trig(trig), .cnt_pin(cpin), .rx_n(rx_n), .tx_n(tx_n));
  // ********
  // helpers
  // ********
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdat = v;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    rv   = rdat;
  endtask : rd
  task automatic go(input logic t);
    @(negedge clk);
    if (t)
      tg = 1'b1;
    else
      cg = 1'b1;
    @(negedge clk);
    tg = 1'b0;
    cg = 1'b0;
  endtask : go
  task automatic setup(input logic [15:0] cap, input logic [15:0] cnt, input logic [7:0] md);
    wr(8'hc8, 8'h00);
    wr(8'hca, cap[7:0]);
    wr(8'hcb, cap[15:8]);
    wr(8'hcc, cnt[7:0]);
    wr(8'hcd, cnt[15:8]);
    wr(8'hc9, md);
  endtask : setup
  function automatic logic [7:0] mode_exp(input logic [7:0] v);
    return {6'h00, v[1:0]};
  endfunction : mode_exp
  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // clock, random other-timer pulses and watchdog
  initial begin
    forever #5 clk = ~clk;
  end
  always @(negedge clk) ovf1 <= ($random(seed) & 3) == 0;
  always @(posedge clk) n1 <= n1 + int'(ovf1);
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
  // ********
  // scenarios
  // ********
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    for (int a = 'hc7; a <= 'hcd; a++) begin
      rd(8'(a));
      chk("reset", rv, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(8'hca + 8'(i % 4), d);
      rd(8'hca + 8'(i % 4));
      chk("rw", rv, d);
      wr(8'hc9, d);
      rd(8'hc9);
      chk("mode", rv, mode_exp(d));
    end
    repeat (30) @(negedge clk);
    rd(8'hcd);
    chk("halt", rv, d);
    // rollover with reload, flag held until software
    setup(16'hfff0, 16'hfffe, 8'h00);
    wr(8'hc8, 8'h04);
    repeat (20) @(negedge clk);
    rd(8'hc8);
    chk("ovf", rv, 8'h84);
    chk("irq", {7'h00, irq}, 8'h01);
    rd(8'hcd);
    chk("reload", rv, 8'hff);
    irq_en = 1'b0;
    @(negedge clk);
    chk("irq_off", {7'h00, irq}, 8'h00);
    irq_en = 1'b1;
    wr(8'hc8, 8'h44);
    rd(8'hc8);
    chk("sw_ext", rv, 8'h44);
    chk("sw_irq", {7'h00, irq}, 8'h01);
    // trigger edge ignored, then capturing
    setup(16'h0000, 16'h1234, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr(8'hc8, e ? 8'h0d : 8'h05);
      go(1'b1);
      repeat (8) @(negedge clk);
      rd(8'hc8);
      chk("xflag", rv, e ? 8'h4d : 8'h05);
      chk("xirq", {7'h00, irq}, e ? 8'h01 : 8'h00);
      rd(8'hcb);
      chk("cap", rv, e ? 8'h12 : 8'h00);
    end
    // trigger edge reloads the count in reload mode
    setup(16'h5678, 16'h0000, 8'h00);
    wr(8'hc8, 8'h0c);
    go(1'b1);
    repeat (8) @(negedge clk);
    rd(8'hcd);
    chk("trg_ld", rv, 8'h56);
    rd(8'hc8);
    chk("trg_flag", rv, 8'h4c);
    chk("trg_irq", {7'h00, irq}, 8'h01);
    // seventeenth bit, then down count to the capture value
    setup(16'h0010, 16'hfffe, 8'h01);
    wr(8'hc8, 8'h04);
    repeat (20) @(negedge clk);
    rd(8'hc8);
    chk("tog", rv, 8'hc4);
    wr(8'hc8, 8'h44);
    chk("tog_irq", {7'h00, irq}, 8'h00);
    dlo = 1'b1;
    repeat (40) @(negedge clk);
    rd(8'hc8);
    chk("down", rv, 8'h84);
    rd(8'hcd);
    chk("down_ld", rv, 8'hff);
    dlo = 1'b0;
    // baud generation on each side, capture select set
    for (int b = 0; b < 2; b++) begin
      setup(16'hfffe, 16'hfffe, 8'h00);
      wr(8'hc8, b ? 8'h15 : 8'h25);
      r0 = b ? tx_n : rx_n;
      t0 = b ? rx_n : tx_n;
      m0 = n1;
      repeat (40) @(negedge clk);
      chk("baud", {7'h00, ((b ? tx_n : rx_n) - r0) inside {[8:11]}}, 8'h01);
      chk("t1", {7'h00, ((b ? rx_n : tx_n) - t0 - (n1 - m0)) inside {[-2:2]}}, 8'h01);
      rd(8'hc8);
      chk("no_ovf", rv, b ? 8'h15 : 8'h25);
    end
    // counting falling edges of the count pin
    setup(16'h0000, 16'h0000, 8'h00);
    wr(8'hc8, 8'h06);
    repeat (5) begin
      go(1'b0);
      repeat (10) @(negedge clk);
    end
    rd(8'hcc);
    chk("cnt", rv, 8'h05);
    // slow timer rate, one tick per twelve clocks
    setup(16'h0000, 16'h0000, 8'h00);
    spd = 1'b0;
    wr(8'hc8, 8'h04);
    repeat (120) @(negedge clk);
    rd(8'hcc);
    chk("slow", {7'h00, (rv inside {[8'h09:8'h0b]})}, 8'h01);
    spd = 1'b1;
    // clock output on the count pin
    setup(16'hffff, 16'hffff, 8'h02);
    wr(8'hc8, 8'h04);
    repeat (20) @(negedge clk);
    chk("oe", {7'h00, oe_n}, 8'h00);
    chk("co_irq", {7'h00, irq}, 8'h00);
    // every rollover flips the pin, one rollover per two clocks
    d = {7'h00, pin_o};
    repeat (2) @(negedge clk);
    chk("co_pin", {7'h00, pin_o}, {7'h00, ~d[0]});
    close_out();
  end
endmodule : testbench
`default_nettype wire
